// ---- ugp_port.v ----
// Eight-pin programmable I/O port with modem-line option
`timescale 1ns/1ps
`include "ugp_regs.vh"
module ugp_port #(
  parameter AW = 4,
  parameter DW = 8
) (
  input  wire          clock,
  input  wire          arst_n,
  input  wire [AW-1:0] regAddr,
  input  wire [DW-1:0] regWrData,
  input  wire          regWrStb,
  input  wire          regRdStb,
  output reg  [DW-1:0] regRdData,
  input  wire [7:0]    pinIn,
  output reg  [7:0]    pinOut,
  output reg  [7:0]    pinOe,
  output reg           pinIrq,
  output reg           modemIrq,
  output reg           softResetPulse
);

  // ***********************************
  // Decoding helpers
  // ***********************************
  function [7:0] gpioOwned;
    input modemMode;
    begin
      gpioOwned = modemMode ? `UGP_GPIO_LOW : `UGP_GPIO_ALL;
    end
  endfunction

  function hit;
    input [AW-1:0] a;
    input [3:0]    ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // ***********************************
  // State
  // ***********************************
  reg  [7:0] dir_ff;
  reg  [7:0] lvl_ff;
  reg  [7:0] mask_ff;
  reg        mode_ff;
  reg        latch_ff;
  reg  [7:0] irqEn_ff;
  reg  [7:0] modemCtl_ff;
  reg  [7:0] prev_ff;
  reg  [7:0] ref_ff;
  reg  [7:0] cap_ff;
  reg  [7:0] pend_ff;
  reg        carrierDelta_ff;
  reg        ringEdge_ff;
  reg        dDsr_ff;
  reg        srst_ff;

  reg  [7:0] nxt_pend;
  reg  [7:0] nxt_ref;
  reg  [7:0] nxt_cap;
  reg  [7:0] nxt_pinOut;
  reg  [7:0] nxt_pinOe;
  reg  [7:0] nxt_rdData;
  reg        nxt_carrierDelta;
  reg        nxt_ringEdge;
  reg        nxt_dDsr;

  wire [7:0] syncIn;

  ugp_sync #(
    .W (8)
  ) uSync (
    .clock  (clock),
    .arst_n (arst_n),
    .din    (pinIn),
    .dout   (syncIn)
  );

  wire [7:0] ownMask = gpioOwned(mode_ff);
  wire [7:0] inMask  = ~dir_ff & ownMask;
  wire [7:0] change  = syncIn ^ prev_ff;
  wire       wrDir   = regWrStb && hit(regAddr, `UGP_OFS_DIR);
  wire       rdLvl   = regRdStb && hit(regAddr, `UGP_OFS_LVL);
  wire       rdModemStat = regRdStb && hit(regAddr, `UGP_OFS_MODEM_STAT);
  wire       wrSrst  = regWrStb && hit(regAddr, `UGP_OFS_CTL)
                       && regWrData[`UGP_CTL_SRST_BIT];

  // Latched pins show the captured value until a level read or DIR write
  wire [7:0] lvlView = latch_ff ? ((pend_ff & cap_ff) | (~pend_ff & syncIn)) : syncIn;
  wire       modemStatusIrq = mode_ff && irqEn_ff[`UGP_IRQEN_MODEM_BIT];
  // A later change must not overwrite the value that raised the pending bit
  wire [7:0] capHold = pend_ff & ~{8{rdLvl || wrDir}};

  // ***********************************
  // Pin-change tracking
  // ***********************************
  always @*
  begin
    nxt_ref = (rdLvl || wrDir) ? syncIn : ref_ff;
    nxt_cap = latch_ff ? ((change & ~capHold & syncIn) | ((capHold | ~change) & cap_ff))
                       : syncIn;
    if (latch_ff)
    begin
      nxt_pend = pend_ff;
      if (rdLvl || wrDir)
        nxt_pend = 8'h00;
      nxt_pend = (nxt_pend | change) & inMask;
    end
    else
    begin
      nxt_pend = (syncIn ^ nxt_ref) & inMask;
    end
    if (wrDir)
      nxt_pend = nxt_pend & change & {8{latch_ff}};
  end

  // ***********************************
  // Modem status deltas
  // ***********************************
  always @*
  begin
    nxt_carrierDelta = rdModemStat ? 1'b0 : carrierDelta_ff;
    nxt_ringEdge     = rdModemStat ? 1'b0 : ringEdge_ff;
    nxt_dDsr         = rdModemStat ? 1'b0 : dDsr_ff;
    if (mode_ff)
    begin
      nxt_carrierDelta = nxt_carrierDelta | change[`UGP_PIN_CARRIER];
      nxt_ringEdge     = nxt_ringEdge | (change[`UGP_PIN_RING] & syncIn[`UGP_PIN_RING]);
      nxt_dDsr = nxt_dDsr | change[`UGP_PIN_DSR];
    end
  end

  // ***********************************
  // Pin drive
  // ***********************************
  always @*
  begin
    nxt_pinOe  = dir_ff & ownMask;
    nxt_pinOut = lvl_ff & nxt_pinOe;
    if (mode_ff)
    begin
      nxt_pinOe  = nxt_pinOe | `UGP_DTR_MASK;
      if (!modemCtl_ff[`UGP_MDMCTL_DTR_BIT])
        nxt_pinOut = nxt_pinOut | `UGP_DTR_MASK;
    end
  end

  // ***********************************
  // Read mux
  // ***********************************
  always @*
  begin
    nxt_rdData = `UGP_RST_BYTE;
    if (regRdStb)
    begin
      case (regAddr)
        `UGP_OFS_DIR:  nxt_rdData = dir_ff;
        `UGP_OFS_LVL:  nxt_rdData = lvlView;
        `UGP_OFS_MASK: nxt_rdData = mask_ff;
        `UGP_OFS_CTL:  nxt_rdData = {6'h00, mode_ff, latch_ff};
        `UGP_OFS_IRQ_EN:    nxt_rdData = irqEn_ff;
        `UGP_OFS_MODEM_CTL: nxt_rdData = modemCtl_ff;
        `UGP_OFS_MODEM_STAT:
        begin
          if (mode_ff)
            nxt_rdData = {~syncIn[`UGP_PIN_CARRIER], ~syncIn[`UGP_PIN_RING],
                          ~syncIn[`UGP_PIN_DSR], 1'b0,
                          carrierDelta_ff, ringEdge_ff, dDsr_ff, 1'b0};
        end
        default:       nxt_rdData = `UGP_RST_BYTE;
      endcase
    end
  end

  // ***********************************
  // Registers
  // ***********************************
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dir_ff         <= `UGP_RST_BYTE;
      lvl_ff         <= `UGP_RST_BYTE;
      mask_ff        <= `UGP_RST_BYTE;
      mode_ff        <= 1'b0;
      latch_ff       <= 1'b0;
      irqEn_ff       <= `UGP_RST_BYTE;
      modemCtl_ff    <= `UGP_RST_BYTE;
      prev_ff        <= `UGP_RST_BYTE;
      ref_ff         <= `UGP_RST_BYTE;
      cap_ff         <= `UGP_RST_BYTE;
      pend_ff        <= `UGP_RST_BYTE;
      carrierDelta_ff <= 1'b0;
      ringEdge_ff    <= 1'b0;
      dDsr_ff        <= 1'b0;
      srst_ff        <= 1'b0;
      regRdData      <= `UGP_RST_BYTE;
      pinOut         <= `UGP_RST_BYTE;
      pinOe          <= `UGP_RST_BYTE;
      pinIrq         <= 1'b0;
      modemIrq       <= 1'b0;
      softResetPulse <= 1'b0;
    end
    else if (srst_ff)
    begin
      dir_ff         <= `UGP_RST_BYTE;
      lvl_ff         <= `UGP_RST_BYTE;
      mask_ff        <= `UGP_RST_BYTE;
      mode_ff        <= 1'b0;
      latch_ff       <= 1'b0;
      irqEn_ff       <= `UGP_RST_BYTE;
      modemCtl_ff    <= `UGP_RST_BYTE;
      prev_ff        <= syncIn;
      ref_ff         <= syncIn;
      cap_ff         <= syncIn;
      pend_ff        <= `UGP_RST_BYTE;
      carrierDelta_ff <= 1'b0;
      ringEdge_ff    <= 1'b0;
      dDsr_ff        <= 1'b0;
      srst_ff        <= 1'b0;
      regRdData      <= `UGP_RST_BYTE;
      pinOut         <= `UGP_RST_BYTE;
      pinOe          <= `UGP_RST_BYTE;
      pinIrq         <= 1'b0;
      modemIrq       <= 1'b0;
      softResetPulse <= 1'b0;
    end
    else
    begin
      if (regWrStb)
      begin
        case (regAddr)
          `UGP_OFS_DIR:  dir_ff  <= regWrData;
          `UGP_OFS_LVL:  lvl_ff  <= regWrData;
          `UGP_OFS_MASK: mask_ff <= regWrData;
          `UGP_OFS_IRQ_EN:    irqEn_ff    <= regWrData;
          `UGP_OFS_MODEM_CTL: modemCtl_ff <= regWrData;
          `UGP_OFS_CTL:
          begin
            mode_ff  <= regWrData[`UGP_CTL_MODE_BIT];
            latch_ff <= regWrData[`UGP_CTL_LATCH_BIT];
          end
          default:       ;
        endcase
      end
      srst_ff        <= wrSrst;
      softResetPulse <= wrSrst;
      prev_ff        <= syncIn;
      ref_ff         <= nxt_ref;
      cap_ff         <= nxt_cap;
      pend_ff        <= nxt_pend;
      carrierDelta_ff <= nxt_carrierDelta;
      ringEdge_ff    <= nxt_ringEdge;
      dDsr_ff        <= nxt_dDsr;
      regRdData      <= nxt_rdData;
      pinOut         <= nxt_pinOut;
      pinOe          <= nxt_pinOe;
      pinIrq         <= |(nxt_pend & mask_ff & ownMask);
      modemIrq       <= modemStatusIrq && (nxt_carrierDelta || nxt_ringEdge || nxt_dDsr);
    end
  end

endmodule // ugp_port

// ---- ugp_regs.vh ----
// Register map, field positions and reset values of the programmable I/O port
`ifndef UGP_REGS_VH
`define UGP_REGS_VH

`define UGP_OFS_IRQ_EN     4'h1
`define UGP_OFS_MODEM_CTL  4'h4
`define UGP_OFS_MODEM_STAT 4'h6
`define UGP_OFS_DIR        4'hA
`define UGP_OFS_LVL        4'hB
`define UGP_OFS_MASK       4'hC
`define UGP_OFS_CTL        4'hE

`define UGP_CTL_LATCH_BIT  0
`define UGP_CTL_MODE_BIT   1
`define UGP_CTL_SRST_BIT   3
`define UGP_IRQEN_MODEM_BIT 3
`define UGP_MDMCTL_DTR_BIT  0

`define UGP_PIN_RING       7
`define UGP_PIN_CARRIER    6
`define UGP_PIN_DTR        5
`define UGP_PIN_DSR        4

`define UGP_GPIO_ALL       8'hFF
`define UGP_GPIO_LOW       8'h0F
`define UGP_DTR_MASK       8'h20
`define UGP_RST_BYTE       8'h00

`endif

// ---- ugp_sync.v ----
// Two-stage synchroniser for the eight pin inputs
`timescale 1ns/1ps
module ugp_sync #(
  parameter W = 8
) (
  input  wire         clock,
  input  wire         arst_n,
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);

  // ***********************************
  // Per-bit double flop
  // ***********************************
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1)
    begin : gSync
      reg meta_ff;
      reg stab_ff;
      always @(posedge clock or negedge arst_n)
      begin
        if (!arst_n)
        begin
          meta_ff <= 1'b0;
          stab_ff <= 1'b0;
        end
        else
        begin
          meta_ff <= din[i];
          stab_ff <= meta_ff;
        end
      end
      assign dout[i] = stab_ff;
    end
  endgenerate

endmodule // ugp_sync

// ---- ugp_port_monitor.sv ----
// Concurrent checks on the I/O port pins and register port
`timescale 1ns/1ps
`include "ugp_regs.vh"
module ugp_port_monitor #(
  parameter AW = 4,
  parameter DW = 8
) (
  input wire          clock,
  input wire          arst_n,
  input wire [AW-1:0] regAddr,
  input wire [DW-1:0] regWrData,
  input wire          regWrStb,
  input wire          regRdStb,
  input wire [DW-1:0] regRdData,
  input wire [7:0]    pinIn,
  input wire [7:0]    pinOut,
  input wire [7:0]    pinOe,
  input wire          pinIrq,
  input wire          modemIrq,
  input wire          softResetPulse
);
  logic [7:0] pinPrev_ff;
  logic [2:0] calm_ff;
  wire srstReq = regWrStb && regAddr == `UGP_OFS_CTL && regWrData[`UGP_CTL_SRST_BIT];
  wire dirWr = regWrStb && regAddr == `UGP_OFS_DIR;
  wire lvlRd = regRdStb && regAddr == `UGP_OFS_LVL;
  // Clears are judged only once pins are quiet past the sync delay
  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n)
    begin
      pinPrev_ff <= 8'h00;
      calm_ff <= 3'h0;
    end
    else
    begin
      pinPrev_ff <= pinIn;
      calm_ff <= (pinIn != pinPrev_ff) ? 3'h0 : calm_ff + {2'h0, calm_ff != 3'h7};
    end
  default clocking dc @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence quiet;
    calm_ff >= 3'h5;
  endsequence
  sequence cleared;
    softResetPulse ##1 (pinOe == 8'h00 && pinOut == 8'h00 && !pinIrq);
  endsequence
  a_srst_pulse: assert property (srstReq |=> cleared)
    else $error("soft reset not done");
  a_pulse_cause: assert property (softResetPulse |-> $past(srstReq))
    else $error("stray reset pulse");
  a_out_gated: assert property ((pinOut & ~pinOe) == 8'h00)
    else $error("undriven pin high");
  a_dir_oe: assert property (dirWr |=> ##1 pinOe[3:0] == $past(regWrData[3:0], 2))
    else $error("enable wrong");
  a_lvl_drive: assert property (regWrStb && regAddr == `UGP_OFS_LVL |=> ##1
    pinOut[3:0] == ($past(regWrData[3:0], 2) & pinOe[3:0]))
    else $error("level wrong");
  a_irq_cause: assert property ($rose(pinIrq) |-> $past(pinIn, 3) != $past(pinIn, 4))
    else $error("irq without change");
  a_dir_clear: assert property (dirWr ##0 quiet |=> ##1 !pinIrq)
    else $error("dir write kept irq");
  a_rd_clear: assert property (lvlRd ##0 quiet |=> ##1 !pinIrq)
    else $error("read kept irq");
endmodule // ugp_port_monitor

bind ugp_port ugp_port_monitor #(.AW(AW), .DW(DW)) monU (.clock(clock), .arst_n(arst_n),
  .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
  .regRdData(regRdData), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pinIrq(pinIrq),
  .modemIrq(modemIrq), .softResetPulse(softResetPulse));

// ---- ugp_pin_model.sv ----
// Outside lines wired to the eight port pins
`timescale 1ns/1ps
module ugp_pin_model (
  input  wire [7:0] pinOut,
  input  wire [7:0] pinOe,
  input  wire [7:0] extLvl,
  output wire [7:0] pinIn
);
  // Driven pins show the port level, the rest the far side's own
  assign pinIn = (pinOe & pinOut) | (~pinOe & extLvl);
endmodule // ugp_pin_model

// ---- ugp_port_bench.sv ----
// Self-checking bench for the I/O port
`timescale 1ns/1ps
`include "ugp_regs.vh"
module ugp_port_bench;
  logic       clock;
  logic       arst_n;
  logic [3:0] regAddr;
  logic [7:0] regWrData;
  logic       regWrStb;
  logic       regRdStb;
  wire  [7:0] regRdData;
  wire  [7:0] pinIn;
  wire  [7:0] pinOut;
  wire  [7:0] pinOe;
  wire        pinIrq;
  wire        modemIrq;
  wire        softResetPulse;
  logic [7:0] extLvl;
  int         fails;
  int         compares;
  ugp_port dut_u (.clock(clock), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .pinIn(pinIn),
    .pinOut(pinOut), .pinOe(pinOe), .pinIrq(pinIrq), .modemIrq(modemIrq),
    .softResetPulse(softResetPulse));
  ugp_pin_model farU (.pinOut(pinOut), .pinOe(pinOe), .extLvl(extLvl), .pinIn(pinIn));
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clock);
    regWrStb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clock);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clock);
    regRdStb <= 1'b0;
    #1;
    chk(regRdData & m, e);
  endtask
  // Six edges cover sync, pending and output flops
  task automatic pin(input logic [7:0] v);
    @(posedge clock);
    extLvl <= v;
    wt(6);
  endtask
  task automatic t_levels;
    wr(`UGP_OFS_DIR, 8'h0F);
    wr(`UGP_OFS_LVL, 8'hA5);
    pin(8'h90);
    chk(pinOe, 8'h0F);
    chk(pinOut, 8'h05);
    rd(`UGP_OFS_LVL, 8'hFF, 8'h95);
    pin(8'h00);
    rd(`UGP_OFS_LVL, 8'hFF, 8'h05);
    $display("t_levels done");
  endtask
  task automatic t_unlatched;
    wr(`UGP_OFS_MASK, 8'h80);
    pin(8'h40);
    chk({7'h00, pinIrq}, 8'h00);
    pin(8'hC0);
    chk({7'h00, pinIrq}, 8'h01);
    pin(8'h40);
    chk({7'h00, pinIrq}, 8'h00);
    pin(8'hC0);
    rd(`UGP_OFS_LVL, 8'h80, 8'h80);
    wt(2);
    chk({7'h00, pinIrq}, 8'h00);
    pin(8'h40);
    wr(`UGP_OFS_DIR, 8'h0F);
    wt(2);
    chk({7'h00, pinIrq}, 8'h00);
    $display("t_unlatched done");
  endtask
  task automatic t_latched;
    wr(`UGP_OFS_CTL, 8'h01);
    pin(8'hC0);
    pin(8'h40);
    chk({7'h00, pinIrq}, 8'h01);
    rd(`UGP_OFS_LVL, 8'h80, 8'h80);
    wt(2);
    chk({7'h00, pinIrq}, 8'h00);
    $display("t_latched done");
  endtask
  task automatic t_modem;
    wr(`UGP_OFS_CTL, 8'h02);
    wr(`UGP_OFS_IRQ_EN, 8'h08);
    wt(1);
    chk(pinOut, 8'h25);
    wr(`UGP_OFS_MODEM_CTL, 8'h01);
    wr(`UGP_OFS_DIR, 8'hFF);
    wt(2);
    chk(pinOe, 8'h2F);
    chk(pinOut, 8'h05);
    rd(`UGP_OFS_MODEM_STAT, 8'hE0, 8'h60);
    // Upper pins are inputs by direction, so only the mode keeps mask bit 7 out
    wr(`UGP_OFS_DIR, 8'h0F);
    pin(8'hC0);
    chk({7'h00, modemIrq}, 8'h01);
    chk({7'h00, pinIrq}, 8'h00);
    rd(`UGP_OFS_MODEM_STAT, 8'hFF, 8'h24);
    // Mask cleared first so stale pin state cannot raise a pin irq
    wr(`UGP_OFS_MASK, 8'h00);
    wr(`UGP_OFS_CTL, 8'h00);
    wr(`UGP_OFS_DIR, 8'hFF);
    wt(2);
    chk(pinOut, 8'hA5);
    wr(`UGP_OFS_DIR, 8'h0F);
    pin(8'h00);
    chk({7'h00, modemIrq}, 8'h00);
    rd(`UGP_OFS_MODEM_STAT, 8'hFF, 8'h00);
    $display("t_modem done");
  endtask
  task automatic t_srst;
    wr(`UGP_OFS_MASK, 8'h0F);
    wr(`UGP_OFS_CTL, 8'h0B);
    #1;
    chk({7'h00, softResetPulse}, 8'h01);
    wt(2);
    chk(pinOe, 8'h00);
    rd(`UGP_OFS_CTL, 8'hFF, 8'h00);
    rd(`UGP_OFS_MASK, 8'hFF, 8'h00);
    rd(4'h0, 8'hFF, 8'h00);
    $display("t_srst done");
  endtask
  task automatic tally_and_finish;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Tests need under 150 cycles; allow ample slack
  initial
  begin
    #50000;
    fails++;
    tally_and_finish;
  end
  initial
  begin
    arst_n = 1'b0;
    regAddr = 4'h0;
    regWrData = 8'h00;
    regWrStb = 1'b0;
    regRdStb = 1'b0;
    extLvl = 8'h00;
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    t_levels;
    t_unlatched;
    t_latched;
    t_modem;
    t_srst;
    tally_and_finish;
  end
endmodule // ugp_port_bench
